//--- hdl/ccr_pkg.sv
package ccr_pkg;

  // ==========================================================================
  // Register addresses and pages
  localparam logic [7:0] CCR_ADDR_CMP2_CTRL = 8'h9a;
  localparam logic [7:0] CCR_ADDR_CMP2_MODE = 8'h9b;
  localparam logic [7:0] CCR_ADDR_CMP2_MUX  = 8'h9c;
  localparam logic [7:0] CCR_ADDR_CMP1_MODE = 8'h9e;
  localparam logic [7:0] CCR_ADDR_CMP1_MUX  = 8'h9f;
  localparam logic [7:0] CCR_PAGE_BASE      = 8'h00;
  localparam logic [7:0] CCR_PAGE_ALT       = 8'h10;

  // ==========================================================================
  // Field positions
  localparam int unsigned CCR_BIT_ENABLE = 7;
  localparam int unsigned CCR_BIT_OUT    = 6;
  localparam int unsigned CCR_BIT_RISE   = 5;
  localparam int unsigned CCR_BIT_FALL   = 4;
  localparam int unsigned CCR_HYP_LSB    = 2;
  localparam int unsigned CCR_HYN_LSB    = 0;
  localparam int unsigned CCR_MODE_LSB   = 0;
  localparam int unsigned CCR_NSEL_LSB   = 4;
  localparam int unsigned CCR_PSEL_LSB   = 0;

  // ==========================================================================
  // Values after reset
  localparam logic [1:0] CCR_MODE_RESET = 2'h2;
  localparam logic [1:0] CCR_HYST_RESET = 2'h0;
  localparam logic [3:0] CCR_SEL_RESET  = 4'h7;
  localparam logic [7:0] CCR_BYTE_ZERO  = 8'h00;

  // ==========================================================================
  // Carriers
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] page;
    logic       wr;
    logic       rd;
    logic [7:0] wdata;
  } ccr_sfr_req_t;

  typedef struct packed {
    logic [3:0] neg;
    logic [3:0] pos;
  } ccr_mux_sel_t;

  typedef struct packed {
    logic       enable;
    logic [1:0] pos_hyst;
    logic [1:0] neg_hyst;
    logic [1:0] mode;
  } ccr_cmp_ctl_t;

  typedef struct packed {
    logic sync1;
    logic sync2;
    logic prev;
  } ccr_sync_state_t;

  typedef struct packed {
    logic         cmp1_rise_irq_en;
    logic         cmp1_fall_irq_en;
    logic [1:0]   cmp1_response_mode;
    ccr_mux_sel_t cmp1_sel;
    ccr_cmp_ctl_t cmp2_ctl;
    logic         cmp2_rise_flag;
    logic         cmp2_fall_flag;
    logic         cmp2_rise_irq_en;
    logic         cmp2_fall_irq_en;
    ccr_mux_sel_t cmp2_sel;
    logic [7:0]   rdata;
    logic         cmp1_irq;
    logic         cmp2_irq;
  } ccr_state_t;

endpackage

//--- hdl/ccr_edge_sync.sv
`timescale 1ns/10ps

module ccr_edge_sync (
  input  wire logic clk_in,
  input  wire logic reset_in,
  input  wire logic raw_in,
  input  wire logic enable_in,
  output logic      level_out,
  output logic      rise_out,
  output logic      fall_out
);

  ccr_pkg::ccr_sync_state_t q;
  ccr_pkg::ccr_sync_state_t d;

  // ==========================================================================
  // Two-stage synchroniser and history
  always_comb begin
    d       = q;
    d.sync1 = raw_in;
    d.sync2 = q.sync1;
    d.prev  = q.sync2;
  end

  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  // Edges only count while enabled; a dead core must not raise flags
  assign level_out = q.sync2;
  assign rise_out  = enable_in & q.sync2 & ~q.prev;
  assign fall_out  = enable_in & ~q.sync2 & q.prev;

endmodule

//--- hdl/ccr_regs.sv
`timescale 1ns/10ps

//
// Contract
// - Mode register bits 7:6 and 3:2 read zero; writes there ignored.
// - First mode bit 5: rising interrupt enable, read/write, resets 0.
// - First mode bit 4: falling interrupt enable, read/write, resets 0.
// - First mode bits 1:0: response mode to core, resets to 10.
// - Control bit 7 enable read/write; bit 6 reads live output state.
// - Control bit 5 set on rising output edge; cleared by writing 0.
// - Control bit 4 set on falling output edge; cleared by writing 0.
// - Control bits 3:2 positive hysteresis code to core, resets 00.
// - Control bits 1:0 negative hysteresis code to core, resets 00.
// - Second mode bits 5 and 4: rise and fall interrupt enables.
// - Second mode bits 1:0: response mode, resets to 10.
// - Control register at 0x9A only on page 0x10, resets zero.
// - Second mode register at 0x9B only on page 0x10.
// - First mode register at 0x9E on page 0x00.
// - Each comparator has its own positive and negative select register.
// - Select registers are independent, so pins may be shared freely.
module ccr_regs (
  input  wire logic                   clk_in,
  input  wire logic                   reset_in,
  input  wire ccr_pkg::ccr_sfr_req_t  sfr_req_in,
  output logic [7:0]                  sfr_rdata_out,
  input  wire logic                   cmp1_rise_flag_in,
  input  wire logic                   cmp1_fall_flag_in,
  input  wire logic                   cmp2_raw_in,
  output logic [1:0]                  cmp1_response_mode_out,
  output ccr_pkg::ccr_mux_sel_t       cmp1_sel_out,
  output ccr_pkg::ccr_cmp_ctl_t       cmp2_ctl_out,
  output ccr_pkg::ccr_mux_sel_t       cmp2_sel_out,
  output logic                        cmp1_irq_out,
  output logic                        cmp2_irq_out
);

  ccr_pkg::ccr_state_t q;
  ccr_pkg::ccr_state_t d;
  logic                cmp2_level;
  logic                cmp2_rise_evt;
  logic                cmp2_fall_evt;
  logic                hit_c2_ctrl;
  logic                hit_c2_mode;
  logic                hit_c2_mux;
  logic                hit_c1_mode;
  logic                hit_c1_mux;

  // ==========================================================================
  // Decode helpers
  function automatic logic f_hit(
    input ccr_pkg::ccr_sfr_req_t req,
    input logic [7:0]            addr,
    input logic [7:0]            page
  );
    f_hit = (req.addr == addr) && (req.page == page);
  endfunction

  // Reserved positions are forced to zero here
  function automatic logic [7:0] f_mode_byte(
    input logic       rise_en,
    input logic       fall_en,
    input logic [1:0] mode
  );
    logic [7:0] b;
    b                              = ccr_pkg::CCR_BYTE_ZERO;
    b[ccr_pkg::CCR_BIT_RISE]       = rise_en;
    b[ccr_pkg::CCR_BIT_FALL]       = fall_en;
    b[ccr_pkg::CCR_MODE_LSB +: 2]  = mode;
    f_mode_byte = b;
  endfunction

  function automatic logic [7:0] f_sel_byte(
    input ccr_pkg::ccr_mux_sel_t sel
  );
    logic [7:0] b;
    b                              = ccr_pkg::CCR_BYTE_ZERO;
    b[ccr_pkg::CCR_NSEL_LSB +: 4]  = sel.neg;
    b[ccr_pkg::CCR_PSEL_LSB +: 4]  = sel.pos;
    f_sel_byte = b;
  endfunction

  // ==========================================================================
  // Comparator output synchroniser and edge detector
  ccr_edge_sync u_cmp2_edge (
    .clk_in    (clk_in),
    .reset_in  (reset_in),
    .raw_in    (cmp2_raw_in),
    .enable_in (q.cmp2_ctl.enable),
    .level_out (cmp2_level),
    .rise_out  (cmp2_rise_evt),
    .fall_out  (cmp2_fall_evt)
  );

  // ==========================================================================
  // Address and page decode
  assign hit_c2_ctrl = f_hit(sfr_req_in, ccr_pkg::CCR_ADDR_CMP2_CTRL,
                             ccr_pkg::CCR_PAGE_ALT);
  assign hit_c2_mode = f_hit(sfr_req_in, ccr_pkg::CCR_ADDR_CMP2_MODE,
                             ccr_pkg::CCR_PAGE_ALT);
  assign hit_c2_mux  = f_hit(sfr_req_in, ccr_pkg::CCR_ADDR_CMP2_MUX,
                             ccr_pkg::CCR_PAGE_ALT);
  assign hit_c1_mode = f_hit(sfr_req_in, ccr_pkg::CCR_ADDR_CMP1_MODE,
                             ccr_pkg::CCR_PAGE_BASE);
  assign hit_c1_mux  = f_hit(sfr_req_in, ccr_pkg::CCR_ADDR_CMP1_MUX,
                             ccr_pkg::CCR_PAGE_BASE);

  // ==========================================================================
  // Next state
  always_comb begin
    d = q;

    // First comparator mode; reserved bits never stored
    if (sfr_req_in.wr && hit_c1_mode) begin
      d.cmp1_rise_irq_en   = sfr_req_in.wdata[ccr_pkg::CCR_BIT_RISE];
      d.cmp1_fall_irq_en   = sfr_req_in.wdata[ccr_pkg::CCR_BIT_FALL];
      d.cmp1_response_mode = sfr_req_in.wdata[ccr_pkg::CCR_MODE_LSB +: 2];
    end

    // Select registers kept apart, no arbitration over shared pins
    if (sfr_req_in.wr && hit_c1_mux) begin
      d.cmp1_sel.neg = sfr_req_in.wdata[ccr_pkg::CCR_NSEL_LSB +: 4];
      d.cmp1_sel.pos = sfr_req_in.wdata[ccr_pkg::CCR_PSEL_LSB +: 4];
    end
    if (sfr_req_in.wr && hit_c2_mux) begin
      d.cmp2_sel.neg = sfr_req_in.wdata[ccr_pkg::CCR_NSEL_LSB +: 4];
      d.cmp2_sel.pos = sfr_req_in.wdata[ccr_pkg::CCR_PSEL_LSB +: 4];
    end

    // Control register; the output state bit is not writable
    if (sfr_req_in.wr && hit_c2_ctrl) begin
      d.cmp2_ctl.enable   = sfr_req_in.wdata[ccr_pkg::CCR_BIT_ENABLE];
      d.cmp2_ctl.pos_hyst = sfr_req_in.wdata[ccr_pkg::CCR_HYP_LSB +: 2];
      d.cmp2_ctl.neg_hyst = sfr_req_in.wdata[ccr_pkg::CCR_HYN_LSB +: 2];
      d.cmp2_rise_flag    = sfr_req_in.wdata[ccr_pkg::CCR_BIT_RISE];
      d.cmp2_fall_flag    = sfr_req_in.wdata[ccr_pkg::CCR_BIT_FALL];
    end

    // Edge sets after the write so a clearing write cannot lose an event
    if (cmp2_rise_evt) begin
      d.cmp2_rise_flag = 1'h1;
    end
    if (cmp2_fall_evt) begin
      d.cmp2_fall_flag = 1'h1;
    end

    // Second comparator mode
    if (sfr_req_in.wr && hit_c2_mode) begin
      d.cmp2_rise_irq_en = sfr_req_in.wdata[ccr_pkg::CCR_BIT_RISE];
      d.cmp2_fall_irq_en = sfr_req_in.wdata[ccr_pkg::CCR_BIT_FALL];
      d.cmp2_ctl.mode    = sfr_req_in.wdata[ccr_pkg::CCR_MODE_LSB +: 2];
    end

    // Read data captured on the strobe; unmapped reads return zero
    if (sfr_req_in.rd) begin
      d.rdata = ccr_pkg::CCR_BYTE_ZERO;
      if (hit_c1_mode) begin
        d.rdata = f_mode_byte(q.cmp1_rise_irq_en, q.cmp1_fall_irq_en,
                              q.cmp1_response_mode);
      end
      if (hit_c2_mode) begin
        d.rdata = f_mode_byte(q.cmp2_rise_irq_en, q.cmp2_fall_irq_en,
                              q.cmp2_ctl.mode);
      end
      if (hit_c1_mux) begin
        d.rdata = f_sel_byte(q.cmp1_sel);
      end
      if (hit_c2_mux) begin
        d.rdata = f_sel_byte(q.cmp2_sel);
      end
      if (hit_c2_ctrl) begin
        d.rdata[ccr_pkg::CCR_BIT_ENABLE]     = q.cmp2_ctl.enable;
        d.rdata[ccr_pkg::CCR_BIT_OUT]        = cmp2_level;
        d.rdata[ccr_pkg::CCR_BIT_RISE]       = q.cmp2_rise_flag;
        d.rdata[ccr_pkg::CCR_BIT_FALL]       = q.cmp2_fall_flag;
        d.rdata[ccr_pkg::CCR_HYP_LSB +: 2]   = q.cmp2_ctl.pos_hyst;
        d.rdata[ccr_pkg::CCR_HYN_LSB +: 2]   = q.cmp2_ctl.neg_hyst;
      end
    end

    // Requests built from next values so they line up with the flags
    d.cmp1_irq = (cmp1_rise_flag_in & d.cmp1_rise_irq_en) |
                 (cmp1_fall_flag_in & d.cmp1_fall_irq_en);
    d.cmp2_irq = (d.cmp2_rise_flag & d.cmp2_rise_irq_en) |
                 (d.cmp2_fall_flag & d.cmp2_fall_irq_en);
  end

  // ==========================================================================
  // State register
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      q                    <= '0;
      q.cmp1_response_mode <= ccr_pkg::CCR_MODE_RESET;
      q.cmp2_ctl.mode      <= ccr_pkg::CCR_MODE_RESET;
      q.cmp2_ctl.pos_hyst  <= ccr_pkg::CCR_HYST_RESET;
      q.cmp2_ctl.neg_hyst  <= ccr_pkg::CCR_HYST_RESET;
      q.cmp1_sel.neg       <= ccr_pkg::CCR_SEL_RESET;
      q.cmp1_sel.pos       <= ccr_pkg::CCR_SEL_RESET;
      q.cmp2_sel.neg       <= ccr_pkg::CCR_SEL_RESET;
      q.cmp2_sel.pos       <= ccr_pkg::CCR_SEL_RESET;
    end else begin
      q <= d;
    end
  end

  // ==========================================================================
  // Outputs, all straight from the state register
  assign sfr_rdata_out          = q.rdata;
  assign cmp1_response_mode_out = q.cmp1_response_mode;
  assign cmp1_sel_out           = q.cmp1_sel;
  assign cmp2_ctl_out           = q.cmp2_ctl;
  assign cmp2_sel_out           = q.cmp2_sel;
  assign cmp1_irq_out           = q.cmp1_irq;
  assign cmp2_irq_out           = q.cmp2_irq;

  // ==========================================================================
  // Checks
  sequence s_c2_ctrl_wr;
    sfr_req_in.wr && hit_c2_ctrl;
  endsequence

  sequence s_c2_mode_wr;
    sfr_req_in.wr && hit_c2_mode;
  endsequence

  a_mode_reserved_zero: assert property (
    @(posedge clk_in) disable iff (reset_in)
    sfr_req_in.rd && (hit_c1_mode || hit_c2_mode) |=>
      (sfr_rdata_out[7:6] == 2'h0) && (sfr_rdata_out[3:2] == 2'h0))
    else $error("reserved mode bits read nonzero");

  a_c1_rise_en: assert property (
    @(posedge clk_in) disable iff (reset_in)
    sfr_req_in.wr && hit_c1_mode |=>
      q.cmp1_rise_irq_en == $past(sfr_req_in.wdata[5]))
    else $error("cmp1 rise enable not written");

  a_c1_fall_en: assert property (
    @(posedge clk_in) disable iff (reset_in)
    sfr_req_in.wr && hit_c1_mode |=>
      q.cmp1_fall_irq_en == $past(sfr_req_in.wdata[4]))
    else $error("cmp1 fall enable not written");

  a_c1_mode_drive: assert property (
    @(posedge clk_in) disable iff (reset_in)
    sfr_req_in.wr && hit_c1_mode |=>
      cmp1_response_mode_out == $past(sfr_req_in.wdata[1:0]))
    else $error("cmp1 response mode not driven");

  a_out_state_read: assert property (
    @(posedge clk_in) disable iff (reset_in)
    sfr_req_in.rd && hit_c2_ctrl |=> sfr_rdata_out[6] == $past(cmp2_level))
    else $error("output state bit wrong on read");

  a_rise_flag_sticky: assert property (
    @(posedge clk_in) disable iff (reset_in)
    cmp2_rise_evt or (q.cmp2_rise_flag && !(sfr_req_in.wr && hit_c2_ctrl))
      |=> q.cmp2_rise_flag)
    else $error("rise flag lost");

  a_fall_flag_sticky: assert property (
    @(posedge clk_in) disable iff (reset_in)
    cmp2_fall_evt or (q.cmp2_fall_flag && !(sfr_req_in.wr && hit_c2_ctrl))
      |=> q.cmp2_fall_flag)
    else $error("fall flag lost");

  a_hyst_drive: assert property (
    @(posedge clk_in) disable iff (reset_in)
    s_c2_ctrl_wr |=> (cmp2_ctl_out.pos_hyst == $past(sfr_req_in.wdata[3:2])) &&
      (cmp2_ctl_out.neg_hyst == $past(sfr_req_in.wdata[1:0])))
    else $error("hysteresis code not driven");

  a_c2_mode_write: assert property (
    @(posedge clk_in) disable iff (reset_in)
    s_c2_mode_wr |=> (cmp2_ctl_out.mode == $past(sfr_req_in.wdata[1:0])) &&
      (q.cmp2_rise_irq_en == $past(sfr_req_in.wdata[5])) &&
      (q.cmp2_fall_irq_en == $past(sfr_req_in.wdata[4])))
    else $error("cmp2 mode register not written");

  a_page_guard: assert property (
    @(posedge clk_in) disable iff (reset_in)
    sfr_req_in.wr && (sfr_req_in.page != ccr_pkg::CCR_PAGE_ALT) &&
      !cmp2_rise_evt && !cmp2_fall_evt |=> $stable(cmp2_ctl_out) &&
      $stable(q.cmp2_rise_flag) && $stable(q.cmp2_rise_irq_en))
    else $error("wrong page altered cmp2 registers");

  a_c1_page_guard: assert property (
    @(posedge clk_in) disable iff (reset_in)
    sfr_req_in.wr && (sfr_req_in.page != ccr_pkg::CCR_PAGE_BASE) |=>
      $stable(cmp1_response_mode_out) && $stable(cmp1_sel_out))
    else $error("wrong page altered cmp1 registers");

  a_sel_separate: assert property (
    @(posedge clk_in) disable iff (reset_in)
    sfr_req_in.wr && hit_c2_mux |=> $stable(cmp1_sel_out) &&
      (cmp2_sel_out == $past(sfr_req_in.wdata)))
    else $error("select registers not independent");

  a_irq_level: assert property (
    @(posedge clk_in) disable iff (reset_in)
    cmp2_irq_out == ((q.cmp2_rise_flag && q.cmp2_rise_irq_en) ||
                     (q.cmp2_fall_flag && q.cmp2_fall_irq_en)))
    else $error("cmp2 interrupt request mismatch");

endmodule

//--- verification/ccr_cmp_model.sv
`timescale 1ns/10ps

// ============================================================================
// Analog comparator core stand-in for the second comparator
module ccr_cmp_model (
  input  wire logic                  clk_in,
  input  wire ccr_pkg::ccr_cmp_ctl_t ctl_in,
  input  wire logic                  diff_pos_in,
  output logic                       raw_out
);
  logic [3:0] dly_q;

  // Input pins taken as analog and skipped by the crossbar
  always_ff @(posedge clk_in) begin
    dly_q <= {dly_q[2:0], diff_pos_in};
  end

  // Slower modes settle later; output not gated by enable, which is harsher
  always_comb begin
    raw_out = dly_q[ctl_in.mode];
  end
endmodule

//--- verification/ccr_regs_tb.sv
`timescale 1ns/10ps

module ccr_regs_tb;
  // ==========================================================================
  // Signals
  logic                  clk_in;
  logic                  reset_in;
  ccr_pkg::ccr_sfr_req_t req;
  logic [7:0]            rdata;
  logic                  c1_rise;
  logic                  c1_fall;
  logic                  diff_pos;
  logic                  raw;
  logic                  irq1;
  logic                  irq2;
  logic [1:0]            mode1;
  ccr_pkg::ccr_mux_sel_t sel1;
  ccr_pkg::ccr_mux_sel_t sel2;
  ccr_pkg::ccr_cmp_ctl_t ctl2;
  int                    n_mismatch;
  int                    checks;
  int                    cycles;

  ccr_regs i_ccr_regs (
    .clk_in                 (clk_in),
    .reset_in               (reset_in),
    .sfr_req_in             (req),
    .sfr_rdata_out          (rdata),
    .cmp1_rise_flag_in      (c1_rise),
    .cmp1_fall_flag_in      (c1_fall),
    .cmp2_raw_in            (raw),
    .cmp1_response_mode_out (mode1),
    .cmp1_sel_out           (sel1),
    .cmp2_ctl_out           (ctl2),
    .cmp2_sel_out           (sel2),
    .cmp1_irq_out           (irq1),
    .cmp2_irq_out           (irq2)
  );

  ccr_cmp_model i_ccr_cmp_model (
    .clk_in      (clk_in),
    .ctl_in      (ctl2),
    .diff_pos_in (diff_pos),
    .raw_out     (raw)
  );

  // ==========================================================================
  // Clock and hang guard; the whole run needs well under two hundred cycles
  initial begin
    clk_in = 1'b0;
    forever #25 clk_in = ~clk_in;
  end

  always @(posedge clk_in) begin
    cycles++;
    if (cycles == 2000) begin
      n_mismatch++;
      finish_test();
    end
  end

  // ==========================================================================
  // Shared tasks
  task automatic finish_test;
    $display("checks %0d mismatches %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // One strobe, held across exactly one taking edge
  task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] p,
                     input logic [7:0] d);
    @(posedge clk_in);
    #1;
    req = '{addr: a, page: p, wr: w, rd: !w, wdata: d};
    @(posedge clk_in);
    #1;
    req.wr = 1'b0;
    req.rd = 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] p, input logic [7:0] exp);
    bus(1'b0, a, p, 8'h00);
    chk(rdata, exp);
  endtask

  // Bounded wait: slowest mode plus synchroniser stays well inside 16
  task automatic wait_irq;
    int n;
    n = 0;
    while (irq2 !== 1'b1 && n < 16) begin
      @(posedge clk_in);
      #1;
      n++;
    end
    chk({7'h00, irq2}, 8'h01);
  endtask

  // ==========================================================================
  // Scenarios
  task automatic t_reset;
    rd(ccr_pkg::CCR_ADDR_CMP2_CTRL, ccr_pkg::CCR_PAGE_ALT, 8'h00);
    rd(ccr_pkg::CCR_ADDR_CMP2_MODE, ccr_pkg::CCR_PAGE_ALT, 8'h02);
    rd(ccr_pkg::CCR_ADDR_CMP1_MODE, ccr_pkg::CCR_PAGE_BASE, 8'h02);
    chk({1'b0, ctl2}, 8'h02);
    chk({6'h00, mode1}, 8'h02);
    chk({6'h00, irq1, irq2}, 8'h00);
    chk(sel1, 8'h77);
    chk(sel2, 8'h77);
  endtask

  // Every response mode, with unused bits written as ones and enables toggled
  task automatic t_modes;
    logic [1:0] m;
    for (int i = 0; i < 4; i++) begin
      m = i[1:0];
      bus(1'b1, ccr_pkg::CCR_ADDR_CMP1_MODE, ccr_pkg::CCR_PAGE_BASE, {2'b11, m, 2'b11, m});
      bus(1'b1, ccr_pkg::CCR_ADDR_CMP2_MODE, ccr_pkg::CCR_PAGE_ALT, {2'b11, ~m, 2'b11, m});
      rd(ccr_pkg::CCR_ADDR_CMP1_MODE, ccr_pkg::CCR_PAGE_BASE, {2'b00, m, 2'b00, m});
      rd(ccr_pkg::CCR_ADDR_CMP2_MODE, ccr_pkg::CCR_PAGE_ALT, {2'b00, ~m, 2'b00, m});
      chk({6'h00, mode1}, {6'h00, m});
      chk({6'h00, ctl2.mode}, {6'h00, m});
    end
  endtask

  // Wrong pages must neither write nor answer
  task automatic t_pages;
    bus(1'b1, ccr_pkg::CCR_ADDR_CMP1_MODE, ccr_pkg::CCR_PAGE_ALT, 8'h10);
    rd(ccr_pkg::CCR_ADDR_CMP1_MODE, ccr_pkg::CCR_PAGE_BASE, 8'h33);
    bus(1'b1, ccr_pkg::CCR_ADDR_CMP2_MODE, ccr_pkg::CCR_PAGE_BASE, 8'h10);
    rd(ccr_pkg::CCR_ADDR_CMP2_MODE, ccr_pkg::CCR_PAGE_ALT, 8'h03);
    bus(1'b1, ccr_pkg::CCR_ADDR_CMP2_CTRL, ccr_pkg::CCR_PAGE_BASE, 8'h8f);
    rd(ccr_pkg::CCR_ADDR_CMP2_CTRL, ccr_pkg::CCR_PAGE_BASE, 8'h00);
    rd(ccr_pkg::CCR_ADDR_CMP2_CTRL, ccr_pkg::CCR_PAGE_ALT, 8'h00);
  endtask

  // Hysteresis codes; the read-only output bit is written 1 and must stay 0
  task automatic t_hyst;
    logic [1:0] h;
    for (int i = 0; i < 4; i++) begin
      h = i[1:0];
      bus(1'b1, ccr_pkg::CCR_ADDR_CMP2_CTRL, ccr_pkg::CCR_PAGE_ALT, {4'h4, h, ~h});
      rd(ccr_pkg::CCR_ADDR_CMP2_CTRL, ccr_pkg::CCR_PAGE_ALT, {4'h0, h, ~h});
      chk({4'h0, ctl2.pos_hyst, ctl2.neg_hyst}, {4'h0, h, ~h});
    end
  endtask

  task automatic t_edges;
    bus(1'b1, ccr_pkg::CCR_ADDR_CMP2_CTRL, ccr_pkg::CCR_PAGE_ALT, 8'h80);
    chk({7'h00, ctl2.enable}, 8'h01);
    bus(1'b1, ccr_pkg::CCR_ADDR_CMP2_MODE, ccr_pkg::CCR_PAGE_ALT, 8'h30);
    diff_pos = 1'b1;
    wait_irq();
    rd(ccr_pkg::CCR_ADDR_CMP2_CTRL, ccr_pkg::CCR_PAGE_ALT, 8'he0);
    // Rise flag still set but its enable dropped: request must fall
    bus(1'b1, ccr_pkg::CCR_ADDR_CMP2_MODE, ccr_pkg::CCR_PAGE_ALT, 8'h10);
    chk({7'h00, irq2}, 8'h00);
    bus(1'b1, ccr_pkg::CCR_ADDR_CMP2_CTRL, ccr_pkg::CCR_PAGE_ALT, 8'h80);
    rd(ccr_pkg::CCR_ADDR_CMP2_CTRL, ccr_pkg::CCR_PAGE_ALT, 8'hc0);
    chk({7'h00, irq2}, 8'h00);
    // Slowest response mode for the falling edge
    bus(1'b1, ccr_pkg::CCR_ADDR_CMP2_MODE, ccr_pkg::CCR_PAGE_ALT, 8'h33);
    diff_pos = 1'b0;
    wait_irq();
    rd(ccr_pkg::CCR_ADDR_CMP2_CTRL, ccr_pkg::CCR_PAGE_ALT, 8'h90);
    // Disabled: a rising edge must leave the flags clear
    // The model is not gated by enable, so the level bit still reads high
    bus(1'b1, ccr_pkg::CCR_ADDR_CMP2_CTRL, ccr_pkg::CCR_PAGE_ALT, 8'h00);
    diff_pos = 1'b1;
    repeat (12) @(posedge clk_in);
    #1;
    rd(ccr_pkg::CCR_ADDR_CMP2_CTRL, ccr_pkg::CCR_PAGE_ALT, 8'h40);
    chk({7'h00, irq2}, 8'h00);
  endtask

  // Same pins chosen by both comparators, then changed on one only
  task automatic t_mux;
    bus(1'b1, ccr_pkg::CCR_ADDR_CMP2_MUX, ccr_pkg::CCR_PAGE_ALT, 8'h25);
    bus(1'b1, ccr_pkg::CCR_ADDR_CMP1_MUX, ccr_pkg::CCR_PAGE_BASE, 8'h25);
    chk(sel1, 8'h25);
    chk(sel2, 8'h25);
    bus(1'b1, ccr_pkg::CCR_ADDR_CMP1_MUX, ccr_pkg::CCR_PAGE_BASE, 8'hb0);
    chk(sel1, 8'hb0);
    chk(sel2, 8'h25);
    rd(ccr_pkg::CCR_ADDR_CMP2_MUX, ccr_pkg::CCR_PAGE_ALT, 8'h25);
    rd(ccr_pkg::CCR_ADDR_CMP1_MUX, ccr_pkg::CCR_PAGE_BASE, 8'hb0);
  endtask

  // First comparator request follows its flags and enables
  task automatic t_irq1;
    c1_rise = 1'b1;
    repeat (2) @(posedge clk_in);
    #1;
    chk({7'h00, irq1}, 8'h01);
    bus(1'b1, ccr_pkg::CCR_ADDR_CMP1_MODE, ccr_pkg::CCR_PAGE_BASE, 8'h13);
    repeat (2) @(posedge clk_in);
    #1;
    chk({7'h00, irq1}, 8'h00);
    c1_rise = 1'b0;
    c1_fall = 1'b1;
    repeat (2) @(posedge clk_in);
    #1;
    chk({7'h00, irq1}, 8'h01);
  endtask

  // ==========================================================================
  // Main sequence
  initial begin
    n_mismatch = 0;
    checks = 0;
    cycles = 0;
    req = '0;
    c1_rise = 1'b0;
    c1_fall = 1'b0;
    diff_pos = 1'b0;
    reset_in = 1'b1;
    repeat (2) @(posedge clk_in);
    #1;
    reset_in = 1'b0;
    t_reset();
    t_modes();
    t_pages();
    t_hyst();
    t_edges();
    t_mux();
    t_irq1();
    finish_test();
  end
endmodule
